// [rtl/irs_seq_pkg.sv]
// constants, register map and state types for the integration sequencer
package irs_seq_pkg;
  localparam int NUM_CH = 64;
  localparam int CH_AW = 6;
  localparam int BUS_AW = 10;
  localparam int CNT_W = 7;
  localparam int RD_CNT_W = 8;

  // detector clock counts in the reset phase
  localparam logic [CNT_W-1:0] SEQ_RST_CLKS = 7'h20;
  localparam logic [CNT_W-1:0] SIM_RST_CLKS = 7'h08;
  localparam logic [CNT_W-1:0] BYPASS_CLKS = 7'h40;
  // detector clocks needed to finish a readout
  localparam logic [RD_CNT_W-1:0] SEQ_READ_CLKS = 8'h85;
  localparam logic [RD_CNT_W-1:0] SIM_READ_CLKS = 8'h21;

  // register byte addresses
  localparam logic [BUS_AW-1:0] ADDR_CTRL = 10'h000;
  localparam logic [BUS_AW-1:0] ADDR_STATUS = 10'h004;
  localparam logic [BUS_AW-1:0] ADDR_CLKCNT = 10'h008;
  localparam logic [1:0] DIFF_PAGE = 2'h1;

  // control register fields and reset value
  localparam int CTRL_DIR_DOWN = 0;
  localparam int CTRL_SIMULT = 1;
  localparam int CTRL_DUMP = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // status register fields
  localparam int ST_PHASE = 0;
  localparam int ST_RST_SW = 2;
  localparam int ST_RD_ACTIVE = 3;
  localparam int ST_READY = 4;
  localparam int ST_CAP_BUSY = 5;

  // synchronised pin vector positions
  localparam int PIN_DCLK = 0;
  localparam int PIN_INTEGRATOR_RESET_STROBE = 1;
  localparam int PIN_RSMP = 2;
  localparam int PIN_SSMP = 3;
  localparam int PIN_INTW = 4;
  localparam int PIN_STRT = 5;
  localparam int NUM_PINS = 6;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RESET = 2'b01,
    PH_INTEG = 2'b10
  } phase_e;
endpackage

// [rtl/ch_sample_mem.sv]
// per-channel sample store, one write port, registered read port
`timescale 1ns/100ps
module ch_sample_mem #(
  parameter int DW = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule

// [rtl/integrator_reset_sample_sequencer.sv]
// integration phase sequencer with correlated double sampling store
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - reset phase starts on reset strobe rise, ends on next reset-sample rise
// - sequential mode: reset switch closed until end of 32nd clock
// - simultaneous mode: reset switch closed only until 8th clock
// - reset-sample switch closed until reset-sample rise, filter bypass closed until 64th clock falling edge
// - 64th clock falling edge opens reset-sample filter bypass
// - reset-sample strobe rise opens reset-sample switch, holds reset level
// - during reset drive outputs to lower reference (up) or upper (down)
// - integrate whenever reset switch is open, regardless of window
// - signal filter bypassed while window high, enabled on its fall
// - signal-sample strobe rise samples every integrator output
// - each channel presents signal sample minus reset sample
// - integration ends on signal-sample fall; all 64 samples ready
// - read active low output low while readout in progress
// - timing controller drives the strobes and the detector clock
// - charge dump control dumps compensation charge on integrators
// - direction select high means integrate down, low integrate up
// - output select high means simultaneous, low sequential mode
module integrator_reset_sample_sequencer
  import irs_seq_pkg::*;
#(
  parameter int LEVEL_DW = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic detClk,
  input wire logic integratorResetStrobe,
  input wire logic resetSampleStrobe,
  input wire logic signalSampleStrobe,
  input wire logic integrateWindow,
  input wire logic readoutStartPulse,
  input wire logic [LEVEL_DW-1:0] levelData,
  output logic [irs_seq_pkg::CH_AW-1:0] levelChan,
  output logic levelSampling,
  output logic resetSwitchClosed,
  output logic resetSampleSwitchClosed,
  output logic resetFilterBypass,
  output logic signalFilterBypass,
  output logic integrating,
  output logic driveUpperRef,
  output logic driveLowerRef,
  output logic chargeDump,
  output logic readActiveLow,
  input wire logic [irs_seq_pkg::BUS_AW-1:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  input wire logic [3:0] avByteEnable,
  output logic [31:0] avReadData,
  output logic avWaitRequest
);
  import irs_seq_pkg::*;

  function automatic logic regHit(input logic [BUS_AW-1:0] a, input logic [BUS_AW-1:0] off);
    regHit = (a == off);
  endfunction

  // pin synchronisers: stage A feeds only stage B
  logic [NUM_PINS-1:0] syncA_r, syncB_r, prev_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
      prev_r <= '0;
    end else begin
      syncA_r <= {readoutStartPulse, integrateWindow, signalSampleStrobe,
                  resetSampleStrobe, integratorResetStrobe, detClk};
      syncB_r <= syncA_r;
      prev_r <= syncB_r;
    end
  end

  wire [NUM_PINS-1:0] pinRise = syncB_r & ~prev_r;
  wire [NUM_PINS-1:0] pinFall = ~syncB_r & prev_r;
  wire detRise = pinRise[PIN_DCLK];
  wire detFall = pinFall[PIN_DCLK];
  wire irstRise = pinRise[PIN_INTEGRATOR_RESET_STROBE];
  wire shrRise = pinRise[PIN_RSMP];
  wire shsRise = pinRise[PIN_SSMP];
  wire shsFall = pinFall[PIN_SSMP];
  wire intgFall = pinFall[PIN_INTW];
  wire stiRise = pinRise[PIN_STRT];
  wire stiFall = pinFall[PIN_STRT];

  // control register
  logic [CTRL_W-1:0] ctrl_r;
  wire dirDown = ctrl_r[CTRL_DIR_DOWN];
  wire simMode = ctrl_r[CTRL_SIMULT];

  // integration phase sequencing
  phase_e phase_r, phase_nxt;
  logic [CNT_W-1:0] clkCnt_r;
  logic resetSw_r, shrSw_r, rstBypass_r, sigBypass_r, integ_r;
  logic upperRef_r, lowerRef_r, ready_r;

  always_comb begin
    phase_nxt = phase_r;
    if (irstRise) begin
      phase_nxt = PH_RESET;
    end else begin
      case (phase_r)
        PH_RESET: begin
          if (shrRise) begin
            phase_nxt = PH_INTEG;
          end
        end
        PH_INTEG: begin
          if (shsFall) begin
            phase_nxt = PH_IDLE;
          end
        end
        default: phase_nxt = phase_r;
      endcase
    end
  end

  wire cntSat = (clkCnt_r == BYPASS_CLKS);
  wire seqOpen = !simMode && detFall && (clkCnt_r == SEQ_RST_CLKS);
  wire simOpen = simMode && detRise && (clkCnt_r == SIM_RST_CLKS - 7'h1);
  wire bypassOpen = detFall && cntSat;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r <= PH_IDLE;
      clkCnt_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      if (irstRise) begin
        clkCnt_r <= '0;
      end else if (detRise && !cntSat) begin
        clkCnt_r <= clkCnt_r + 7'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resetSw_r <= 1'b0;
      shrSw_r <= 1'b0;
      rstBypass_r <= 1'b0;
    end else if (irstRise) begin
      resetSw_r <= 1'b1;
      shrSw_r <= 1'b1;
      rstBypass_r <= 1'b1;
    end else begin
      if (seqOpen || simOpen) begin
        resetSw_r <= 1'b0;
      end
      if (bypassOpen) begin
        rstBypass_r <= 1'b0;
      end
      if (shrRise) begin
        shrSw_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sigBypass_r <= 1'b0;
      integ_r <= 1'b0;
      upperRef_r <= 1'b0;
      lowerRef_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      sigBypass_r <= syncB_r[PIN_INTW];
      integ_r <= !resetSw_r;
      upperRef_r <= resetSw_r && dirDown;
      lowerRef_r <= resetSw_r && !dirDown;
      if (shsFall && phase_r == PH_INTEG) begin
        ready_r <= 1'b1;
      end else if (irstRise) begin
        ready_r <= 1'b0;
      end
    end
  end

  // channel capture walk: one channel per core clock
  logic capBusy_r, capSig_r, diffPend_r;
  logic [CH_AW-1:0] chan_r, chanHold_r;
  logic [LEVEL_DW-1:0] levelHold_r, rsData, diffRData;
  wire capLast = (chan_r == CH_AW'(NUM_CH - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      capBusy_r <= 1'b0;
      capSig_r <= 1'b0;
      chan_r <= '0;
    end else if (shrRise || shsRise) begin
      capBusy_r <= 1'b1;
      capSig_r <= shsRise;
      chan_r <= '0;
    end else if (capBusy_r) begin
      capBusy_r <= !capLast;
      chan_r <= capLast ? chan_r : chan_r + CH_AW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      diffPend_r <= 1'b0;
      chanHold_r <= '0;
      levelHold_r <= '0;
    end else begin
      diffPend_r <= capBusy_r && capSig_r;
      chanHold_r <= chan_r;
      levelHold_r <= levelData;
    end
  end

  // difference wraps at the level width, as a two's-complement subtraction
  wire [LEVEL_DW-1:0] diffWData = levelHold_r - rsData;
  wire [CH_AW-1:0] busChan = avAddress[CH_AW+1:2];

  ch_sample_mem #(.DW(LEVEL_DW), .DEPTH(NUM_CH), .AW(CH_AW)) u_reset_mem (
    .core_clk(core_clk),
    .we(capBusy_r && !capSig_r),
    .waddr(chan_r),
    .wdata(levelData),
    .raddr(chan_r),
    .rdata_r(rsData)
  );

  ch_sample_mem #(.DW(LEVEL_DW), .DEPTH(NUM_CH), .AW(CH_AW)) u_diff_mem (
    .core_clk(core_clk),
    .we(diffPend_r),
    .waddr(chanHold_r),
    .wdata(diffWData),
    .raddr(busChan),
    .rdata_r(diffRData)
  );

  // readout busy window, counted in detector clocks
  logic readActLow_r;
  logic [RD_CNT_W-1:0] rdCnt_r;
  wire [RD_CNT_W-1:0] rdLimit = simMode ? SIM_READ_CLKS : SEQ_READ_CLKS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readActLow_r <= 1'b1;
      rdCnt_r <= '0;
    end else if (stiRise) begin
      rdCnt_r <= '0;
    end else if (stiFall) begin
      readActLow_r <= 1'b0;
      rdCnt_r <= '0;
    end else if (!readActLow_r && detRise) begin
      rdCnt_r <= rdCnt_r + 8'h1;
      if (rdCnt_r == rdLimit - 8'h1) begin
        readActLow_r <= 1'b1;
      end
    end
  end

  // avalon slave: request taken, then answered one edge later
  logic busPend_r, waitReq_r;
  logic [31:0] rdData_r;
  wire hitCtrl = regHit(avAddress, ADDR_CTRL);
  wire hitStatus = regHit(avAddress, ADDR_STATUS);
  wire hitClk = regHit(avAddress, ADDR_CLKCNT);
  wire hitDiff = (avAddress[BUS_AW-1:8] == DIFF_PAGE);
  wire [31:0] statusWord = {26'h000_0000, capBusy_r, ready_r, !readActLow_r, resetSw_r,
                            phase_r};
  wire [31:0] rdMux = hitCtrl ? {29'h000_0000, ctrl_r} :
                      hitStatus ? statusWord :
                      hitClk ? {25'h000_0000, clkCnt_r} :
                      hitDiff ? {{(32-LEVEL_DW){1'b0}}, diffRData} : 32'h0000_0000;
  wire ctrlWrite = !waitReq_r && avWrite && hitCtrl && avByteEnable[0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busPend_r <= 1'b0;
      waitReq_r <= 1'b1;
      rdData_r <= 32'h0000_0000;
    end else if (!waitReq_r) begin
      waitReq_r <= 1'b1;
      busPend_r <= 1'b0;
    end else if (busPend_r) begin
      waitReq_r <= 1'b0;
      rdData_r <= rdMux;
    end else if (avRead || avWrite) begin
      busPend_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrlWrite) begin
      ctrl_r <= avWriteData[CTRL_W-1:0];
    end
  end

  assign levelChan = chan_r;
  assign levelSampling = capBusy_r;
  assign resetSwitchClosed = resetSw_r;
  assign resetSampleSwitchClosed = shrSw_r;
  assign resetFilterBypass = rstBypass_r;
  assign signalFilterBypass = sigBypass_r;
  assign integrating = integ_r;
  assign driveUpperRef = upperRef_r;
  assign driveLowerRef = lowerRef_r;
  assign chargeDump = ctrl_r[CTRL_DUMP];
  assign readActiveLow = readActLow_r;
  assign avReadData = rdData_r;
  assign avWaitRequest = waitReq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_phase_start;
    irstRise |=> phase_r == PH_RESET ##0 resetSw_r && shrSw_r && rstBypass_r;
  endproperty
  a_phase_start: assert property (p_phase_start) else $error("reset phase not entered");
  property p_phase_end;
    phase_r == PH_RESET && shrRise && !irstRise |=> phase_r == PH_INTEG;
  endproperty
  a_phase_end: assert property (p_phase_end) else $error("reset phase not ended");
  property p_seq_open;
    resetSw_r && seqOpen && !irstRise |=> !resetSw_r;
  endproperty
  a_seq_open: assert property (p_seq_open) else $error("seq reset switch late");
  property p_seq_hold;
    !simMode && resetSw_r && clkCnt_r < SEQ_RST_CLKS |=> resetSw_r;
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("seq reset switch early");
  property p_sim_open;
    resetSw_r && simOpen && !irstRise |=> !resetSw_r;
  endproperty
  a_sim_open: assert property (p_sim_open) else $error("sim reset switch late");
  property p_bypass;
    rstBypass_r && bypassOpen && !irstRise |=> !rstBypass_r && $stable(clkCnt_r);
  endproperty
  a_bypass: assert property (p_bypass) else $error("reset bypass not opened");
  property p_bypass_hold;
    rstBypass_r && !cntSat |=> rstBypass_r;
  endproperty
  a_bypass_hold: assert property (p_bypass_hold) else $error("bypass opened early");
  property p_shr_open;
    shrRise && !irstRise |=> !shrSw_r ##1 capBusy_r;
  endproperty
  a_shr_open: assert property (p_shr_open) else $error("reset sample not held");
  property p_ref;
    resetSw_r |=> (upperRef_r == $past(dirDown)) && (lowerRef_r != upperRef_r);
  endproperty
  a_ref: assert property (p_ref) else $error("wrong reset reference");
  property p_integ;
    !resetSw_r ##1 !resetSw_r |=> integ_r;
  endproperty
  a_integ: assert property (p_integ) else $error("not integrating");
  property p_sig_bypass;
    intgFall |=> !sigBypass_r;
  endproperty
  a_sig_bypass: assert property (p_sig_bypass) else $error("signal filter not enabled");
  property p_walk;
    shsRise |=> capBusy_r && chan_r == '0 ##1 chan_r == CH_AW'(1) ##1 diffPend_r;
  endproperty
  a_walk: assert property (p_walk) else $error("signal capture walk wrong");
  property p_ready;
    phase_r == PH_INTEG && shsFall && !irstRise |=> ready_r && phase_r == PH_IDLE;
  endproperty
  a_ready: assert property (p_ready) else $error("samples not ready");
  property p_read;
    stiFall && !stiRise |=> !readActiveLow ##1 !readActiveLow;
  endproperty
  a_read: assert property (p_read) else $error("read active not low");
  property p_bus;
    busPend_r && waitReq_r |=> !avWaitRequest ##1 avWaitRequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");

  c_reset_phase: cover property (irstRise ##[1:1000] shrRise);
  c_ready: cover property (phase_r == PH_INTEG && shsFall);
  c_read_done: cover property (!readActLow_r ##1 readActLow_r);
  c_ctrl_write: cover property (ctrlWrite);
endmodule

// [bench/timing_ctrl_model.sv]
// far-side timing controller: strobes, detector clock and integrator levels
`timescale 1ns/100ps
module timing_ctrl_model
  import irs_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic [irs_seq_pkg::CH_AW-1:0] levelChan,
  input wire logic levelSampling,
  output logic detClk,
  output logic integratorResetStrobe,
  output logic resetSampleStrobe,
  output logic signalSampleStrobe,
  output logic integrateWindow,
  output logic readoutStartPulse,
  output logic [15:0] levelData
);
  import irs_seq_pkg::*;
  logic [NUM_PINS-1:0] pins = '0;
  logic sigPhase = 1'b0;
  logic [15:0] level;
  assign level = sigPhase ? 16'h1000 + 16'(levelChan) * 16'h3 : 16'h0100 + 16'(levelChan);
  // outside a walk the bus shows the inverse, so a stale sample cannot pass
  assign levelData = levelSampling ? level : ~level;
  assign detClk = pins[PIN_DCLK];
  assign integratorResetStrobe = pins[PIN_INTEGRATOR_RESET_STROBE];
  assign resetSampleStrobe = pins[PIN_RSMP];
  assign signalSampleStrobe = pins[PIN_SSMP];
  assign integrateWindow = pins[PIN_INTW];
  assign readoutStartPulse = pins[PIN_STRT];
  // each level lasts 4 core cycles, above the 3 the synchronisers need
  task automatic setPin(input int p, input logic v);
    @(posedge core_clk);
    pins[p] <= v;
    if (p == PIN_SSMP && v) sigPhase <= 1'b1;
    if (p == PIN_INTEGRATOR_RESET_STROBE && v) sigPhase <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // detector clock stands low between bursts
  task automatic clocks(input int n);
    repeat (n) begin
      setPin(PIN_DCLK, 1'b1);
      setPin(PIN_DCLK, 1'b0);
    end
  endtask
endmodule

// [bench/integrator_reset_sample_sequencer_tb.sv]
// self-checking bench for the integration sequencer
`timescale 1ns/100ps
module integrator_reset_sample_sequencer_tb;
  import irs_seq_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [BUS_AW-1:0] avAddress = '0;
  logic avRead = 1'b0;
  logic avWrite = 1'b0;
  logic [31:0] avWriteData = '0;
  logic [3:0] avByteEnable = '0;
  logic [31:0] avReadData;
  logic avWaitRequest;
  logic detClk, integratorResetStrobe, resetSampleStrobe, signalSampleStrobe;
  logic integrateWindow, readoutStartPulse;
  logic [15:0] levelData;
  logic [CH_AW-1:0] levelChan;
  logic levelSampling, resetSwitchClosed, resetSampleSwitchClosed, resetFilterBypass;
  logic signalFilterBypass, integrating, driveUpperRef, driveLowerRef, chargeDump;
  logic readActiveLow;
  int errTotal = 0;
  int checked = 0;

  integrator_reset_sample_sequencer dut (
    .core_clk(core_clk), .rst(rst), .detClk(detClk),
    .integratorResetStrobe(integratorResetStrobe), .resetSampleStrobe(resetSampleStrobe),
    .signalSampleStrobe(signalSampleStrobe), .integrateWindow(integrateWindow),
    .readoutStartPulse(readoutStartPulse), .levelData(levelData), .levelChan(levelChan),
    .levelSampling(levelSampling), .resetSwitchClosed(resetSwitchClosed),
    .resetSampleSwitchClosed(resetSampleSwitchClosed), .resetFilterBypass(resetFilterBypass),
    .signalFilterBypass(signalFilterBypass), .integrating(integrating),
    .driveUpperRef(driveUpperRef), .driveLowerRef(driveLowerRef), .chargeDump(chargeDump),
    .readActiveLow(readActiveLow), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(avByteEnable),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest)
  );

  timing_ctrl_model mdl (
    .core_clk(core_clk), .levelChan(levelChan), .levelSampling(levelSampling),
    .detClk(detClk), .integratorResetStrobe(integratorResetStrobe),
    .resetSampleStrobe(resetSampleStrobe), .signalSampleStrobe(signalSampleStrobe),
    .integrateWindow(integrateWindow), .readoutStartPulse(readoutStartPulse),
    .levelData(levelData)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic results();
    if (errTotal == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic busOp(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] d);
    int n;
    @(posedge core_clk);
    avAddress <= a;
    avWriteData <= wd;
    avByteEnable <= be;
    avWrite <= wr;
    avRead <= ~wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avWaitRequest !== 1'b0);
    // raised, taken, answered: waitrequest is seen low at the third edge
    chk("busLatency", n, 3);
    d = avReadData;
    avRead <= 1'b0;
    avWrite <= 1'b0;
  endtask

  task automatic scan(input int m);
    logic [31:0] d;
    logic [2:0] ctl;
    logic dir;
    logic sim;
    int k;
    dir = m[0];
    sim = m[1];
    ctl = {dir ^ sim, sim, dir};
    busOp(1'b1, ADDR_CTRL, {29'h0, ctl}, 4'hF, d);
    busOp(1'b0, ADDR_CTRL, '0, 4'hF, d);
    chk("ctrl", d, {29'h0, ctl});
    chk("dump", chargeDump, ctl[2]);
    mdl.setPin(PIN_INTEGRATOR_RESET_STROBE, 1'b1);
    mdl.setPin(PIN_INTEGRATOR_RESET_STROBE, 1'b0);
    wt(4);
    chk("rstSw", resetSwitchClosed, 1);
    chk("upper", driveUpperRef, dir);
    chk("lower", driveLowerRef, !dir);
    k = sim ? 8 : 32;
    mdl.clocks(k - 1);
    wt(4);
    chk("rstSwHeld", resetSwitchClosed, 1);
    // simultaneous mode opens on the rise, sequential on the fall
    mdl.setPin(PIN_DCLK, 1'b1);
    wt(4);
    chk("rstSwRise", resetSwitchClosed, !sim);
    mdl.setPin(PIN_DCLK, 1'b0);
    wt(4);
    chk("rstSwOpen", resetSwitchClosed, 0);
    chk("integ", integrating, 1);
    mdl.clocks(63 - k);
    wt(4);
    chk("bypassHeld", resetFilterBypass, 1);
    chk("trackHeld", resetSampleSwitchClosed, 1);
    mdl.clocks(1);
    wt(4);
    chk("bypassOpen", resetFilterBypass, 0);
    busOp(1'b0, ADDR_CLKCNT, '0, 4'hF, d);
    chk("clkCnt", d, 32'(BYPASS_CLKS));
    mdl.setPin(PIN_RSMP, 1'b1);
    wt(4);
    chk("trackOpen", resetSampleSwitchClosed, 0);
    busOp(1'b0, ADDR_STATUS, '0, 4'hF, d);
    chk("phaseInteg", d[1:0], PH_INTEG);
    mdl.setPin(PIN_RSMP, 1'b0);
    wt(80);
    mdl.setPin(PIN_INTW, 1'b1);
    wt(4);
    chk("sigBypass", signalFilterBypass, 1);
    mdl.setPin(PIN_INTW, 1'b0);
    wt(4);
    chk("sigFilter", signalFilterBypass, 0);
    mdl.setPin(PIN_SSMP, 1'b1);
    wt(80);
    mdl.setPin(PIN_SSMP, 1'b0);
    wt(4);
    busOp(1'b0, ADDR_STATUS, '0, 4'hF, d);
    chk("ready", d[ST_READY], 1);
    chk("phaseIdle", d[1:0], PH_IDLE);
    for (int c = 0; c < NUM_CH; c++) begin
      busOp(1'b0, {DIFF_PAGE, CH_AW'(c), 2'b00}, '0, 4'hF, d);
      chk("diff", d[15:0], 16'h0F00 + 16'(2 * c));
    end
    mdl.setPin(PIN_STRT, 1'b1);
    mdl.setPin(PIN_STRT, 1'b0);
    wt(4);
    chk("rdStart", readActiveLow, 0);
    k = sim ? SIM_READ_CLKS : SEQ_READ_CLKS;
    mdl.clocks(k - 1);
    wt(4);
    chk("rdBusy", readActiveLow, 0);
    mdl.clocks(1);
    wt(4);
    chk("rdDone", readActiveLow, 1);
  endtask

  initial begin
    wt(60000);
    errTotal++;
    results();
  end

  initial begin
    logic [31:0] d;
    wt(4);
    rst <= 1'b0;
    wt(2);
    chk("rdIdle", readActiveLow, 1);
    chk("rstSwIdle", resetSwitchClosed, 0);
    chk("dumpIdle", chargeDump, 0);
    // a write without the low byte lane must leave control untouched
    busOp(1'b1, ADDR_CTRL, 32'h0000_0007, 4'h0, d);
    busOp(1'b0, ADDR_CTRL, '0, 4'hF, d);
    chk("ctrlNoLane", d, 32'h0000_0000);
    busOp(1'b0, 10'h00C, '0, 4'hF, d);
    chk("unmapped", d, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      scan(m);
    end
    results();
  end
endmodule
